// File: epi_ctrl.sv
// Pin interrupt controller: sense logic, flags, enables and register port.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "epi_defs.svh"
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Line one sense field in bits 3:2.
// - Line zero sense field in bits 1:0.
// - Line two polarity bit 6: fall/rise.
// - Level mode requests while pin stays low.
// - Pins trigger even when driven as outputs.
// - Lines zero/one sampled before edge detection.
// - Level path needs no clock; line two edges are sampled.
// - Request needs line enable and global enable.
// - Trigger sets flag regardless of enable.
// - Flag clears on entry or written one.
// - Flag stays zero in level mode.
// - Wake qualifies level on two watchdog samples.
// - Line two buffer shutdown may set flag.
module epi_ctrl (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire epi_pkg::epi_bus_req_t bus_in,
    output logic [7:0] rdata_out,
    input wire logic ext_line_zero_in,
    input wire logic ext_line_one_in,
    input wire logic ext_line_two_in,
    input wire logic global_enable_in,
    input wire epi_pkg::epi_ack_t ack_in,
    input wire logic sleep_in,
    input wire logic line_two_buf_off_in,
    input wire logic wdt_tick_in,
    output logic [2:0] req_out,
    output logic irq_out,
    output logic wake_out
);

    epi_pkg::epi_state_t s_r;
    epi_pkg::epi_state_t s_nxt;

    logic line_two_eff;
    logic [2:0] raw_pin;
    logic [2:0] hit;
    logic [2:0] level_mode;
    logic [2:0] level_low;
    logic [2:0] flag_now;
    logic [2:0] en_now;
    logic [2:0] pend;
    logic [2:0] ack_clr;
    logic [2:0] w1c;
    logic level_wake;

    // Bit position of each line in the enable and flag registers.
    function automatic int unsigned line_bit(input int unsigned idx);
        int unsigned pos;
        pos = `EPI_LINE_ZERO_BIT;
        case (idx)
            `EPI_IDX_ONE: pos = `EPI_LINE_ONE_BIT;
            `EPI_IDX_TWO: pos = `EPI_LINE_TWO_BIT;
            default: pos = `EPI_LINE_ZERO_BIT;
        endcase
        return pos;
    endfunction : line_bit

    // Trigger decode of a two-bit sense field on synchronised samples.
    function automatic logic sense_hit(
        input logic [1:0] mode,
        input logic cur,
        input logic old
    );
        logic hit_v;
        hit_v = 1'b0;
        case (mode)
            `EPI_SENSE_ANY: hit_v = cur ^ old;
            `EPI_SENSE_FALL: hit_v = old & ~cur;
            `EPI_SENSE_RISE: hit_v = cur & ~old;
            default: hit_v = 1'b0;
        endcase
        return hit_v;
    endfunction : sense_hit

    // Address match for a register access of either kind.
    function automatic logic addr_is(
        input logic [3:0] addr,
        input logic [3:0] ofs
    );
        return addr == ofs;
    endfunction : addr_is

    // The input buffer of line two reads low once line_two_buf_off_in shuts it off.
    assign line_two_eff = ext_line_two_in & ~line_two_buf_off_in;

    // Pad values are used whatever the pin direction is.
    assign raw_pin = {line_two_eff, ext_line_one_in, ext_line_zero_in};

    always_comb begin
        level_mode = 3'b000;
        level_mode[`EPI_IDX_ZERO] =
            s_r.sense_control[`EPI_LINE_ZERO_SENSE] == `EPI_SENSE_LOW;
        level_mode[`EPI_IDX_ONE] =
            s_r.sense_control[`EPI_LINE_ONE_SENSE] == `EPI_SENSE_LOW;
    end

    always_comb begin
        hit = 3'b000;
        hit[`EPI_IDX_ZERO] = sense_hit(
            s_r.sense_control[`EPI_LINE_ZERO_SENSE],
            s_r.sync_b[`EPI_IDX_ZERO],
            s_r.prev[`EPI_IDX_ZERO]);
        hit[`EPI_IDX_ONE] = sense_hit(
            s_r.sense_control[`EPI_LINE_ONE_SENSE],
            s_r.sync_b[`EPI_IDX_ONE],
            s_r.prev[`EPI_IDX_ONE]);
        if (s_r.control_and_reset_status[`EPI_POLARITY_BIT]) begin
            hit[`EPI_IDX_TWO] = s_r.sync_b[`EPI_IDX_TWO] &
                ~s_r.prev[`EPI_IDX_TWO];
        end else begin
            hit[`EPI_IDX_TWO] = s_r.prev[`EPI_IDX_TWO] &
                ~s_r.sync_b[`EPI_IDX_TWO];
        end
    end

    // Level requests follow the pad directly so they hold without a clock.
    assign level_low = level_mode & ~raw_pin;

    generate
        for (genvar i = 0; i < `EPI_LINES; i++) begin : g_line
            localparam int unsigned BIT = line_bit(i);

            assign flag_now[i] = s_r.line_flags[BIT];
            assign en_now[i] = s_r.line_enable[BIT];

            assign w1c[i] = bus_in.wr & bus_in.wdata[BIT] &
                addr_is(bus_in.addr, `EPI_OFS_FLAGS);

            assign ack_clr[i] = ack_in.ack &
                (ack_in.line == 2'(i));

            // A pending request is a raised flag or a held low level.
            assign pend[i] = flag_now[i] | level_low[i];

            assign req_out[i] = pend[i] & en_now[i] &
                global_enable_in;
        end
    endgenerate

    assign irq_out = |req_out;

    // Low level on an enabled line while asleep, for the wake qualifier.
    assign level_wake = |(level_low & en_now);

    always_comb begin
        s_nxt = s_r;

        // Only the second stage reads the first.
        s_nxt.sync_a = raw_pin;
        s_nxt.sync_b = s_r.sync_a;
        s_nxt.prev = s_r.sync_b;

        // Register writes.
        if (bus_in.wr) begin
            if (addr_is(bus_in.addr, `EPI_OFS_SENSE)) begin
                s_nxt.sense_control = bus_in.wdata;
            end
            if (addr_is(bus_in.addr, `EPI_OFS_CSR)) begin
                s_nxt.control_and_reset_status = bus_in.wdata;
                s_nxt.control_and_reset_status[`EPI_CSR_RSVD_BIT] = 1'b0;
            end
            if (addr_is(bus_in.addr, `EPI_OFS_ENABLE)) begin
                s_nxt.line_enable = bus_in.wdata &
                    `EPI_ENABLE_MASK;
            end
        end

        // Flags: a trigger beats a clear arriving in the same cycle.
        for (int unsigned i = 0; i < `EPI_LINES; i++) begin
            s_nxt.line_flags[line_bit(i)] = hit[i] |
                (flag_now[i] & ~w1c[i] & ~ack_clr[i]);
            if (level_mode[i]) begin
                s_nxt.line_flags[line_bit(i)] = 1'b0;
            end
        end

        // Read data stand only in the cycle after the read strobe.
        s_nxt.rdata = `EPI_ZERO_BYTE;
        if (bus_in.rd) begin
            case (1'b1)
                addr_is(bus_in.addr, `EPI_OFS_SENSE):
                    s_nxt.rdata = s_r.sense_control;
                addr_is(bus_in.addr, `EPI_OFS_CSR):
                    s_nxt.rdata = s_r.control_and_reset_status;
                addr_is(bus_in.addr, `EPI_OFS_ENABLE):
                    s_nxt.rdata = s_r.line_enable;
                addr_is(bus_in.addr, `EPI_OFS_FLAGS):
                    s_nxt.rdata = s_r.line_flags;
                default:
                    s_nxt.rdata = `EPI_ZERO_BYTE;
            endcase
        end

        // Level wake needs the low level seen on two watchdog ticks.
        case (s_r.wake)
            epi_pkg::WK_IDLE: begin
                if (sleep_in && wdt_tick_in && level_wake) begin
                    s_nxt.wake = epi_pkg::WK_SEEN_ONCE;
                end
            end
            epi_pkg::WK_SEEN_ONCE: begin
                if (!sleep_in) begin
                    s_nxt.wake = epi_pkg::WK_IDLE;
                end else if (wdt_tick_in) begin
                    if (level_wake) begin
                        s_nxt.wake = epi_pkg::WK_AWAKE;
                    end else begin
                        s_nxt.wake = epi_pkg::WK_IDLE;
                    end
                end
            end
            epi_pkg::WK_AWAKE: begin
                if (!sleep_in) begin
                    s_nxt.wake = epi_pkg::WK_IDLE;
                end
            end
            default: begin
                s_nxt.wake = epi_pkg::WK_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            s_r.sync_a <= 3'b000;
            s_r.sync_b <= 3'b000;
            s_r.prev <= 3'b000;
            s_r.sense_control <= `EPI_SENSE_RST;
            s_r.control_and_reset_status <= `EPI_CSR_RST;
            s_r.line_enable <= `EPI_ENABLE_RST;
            s_r.line_flags <= `EPI_FLAGS_RST;
            s_r.rdata <= `EPI_ZERO_BYTE;
            s_r.wake <= epi_pkg::WK_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_out = s_r.rdata;

    // An edge flag on line two wakes at once if line two is enabled; a qualified level wakes too.
    // The level request itself still follows the live pin, so a level that
    // vanished during start-up wakes the core with no request left.
    assign wake_out = (s_r.wake == epi_pkg::WK_AWAKE) |
        (flag_now[`EPI_IDX_TWO] & en_now[`EPI_IDX_TWO]);

endmodule : epi_ctrl
`default_nettype wire

// File: epi_defs.svh
// Offsets, field positions, reset values and timing of the pin interrupt block.
`ifndef EPI_DEFS_SVH
`define EPI_DEFS_SVH

`define EPI_ADDR_W 4
`define EPI_DATA_W 8

`define EPI_OFS_SENSE 4'h0
`define EPI_OFS_CSR 4'h1
`define EPI_OFS_ENABLE 4'h2
`define EPI_OFS_FLAGS 4'h3

`define EPI_SENSE_RST 8'h00
`define EPI_CSR_RST 8'h00
`define EPI_ENABLE_RST 8'h00
`define EPI_FLAGS_RST 8'h00
`define EPI_ZERO_BYTE 8'h00

`define EPI_LINE_ZERO_SENSE 1:0
`define EPI_LINE_ONE_SENSE 3:2
`define EPI_POLARITY_BIT 6
`define EPI_CSR_RSVD_BIT 5
`define EPI_LINE_ONE_BIT 7
`define EPI_LINE_ZERO_BIT 6
`define EPI_LINE_TWO_BIT 5
`define EPI_ENABLE_MASK 8'hE0

`define EPI_SENSE_LOW 2'h0
`define EPI_SENSE_ANY 2'h1
`define EPI_SENSE_FALL 2'h2
`define EPI_SENSE_RISE 2'h3

`define EPI_LINES 3
`define EPI_IDX_ZERO 0
`define EPI_IDX_ONE 1
`define EPI_IDX_TWO 2

`define EPI_CLK_PERIOD_PS 5000
`define EPI_T2_MIN_PULSE_NS 50
`define EPI_T2_MIN_PULSE_CYC \
    ((`EPI_T2_MIN_PULSE_NS * 1000 + `EPI_CLK_PERIOD_PS - 1) / `EPI_CLK_PERIOD_PS)

`endif

// File: epi_pins.sv
// Board model driving the three interrupt pins.
`include "epi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module epi_pins (
    input wire logic mclk_in,
    output logic [2:0] pins_out
);
    initial pins_out = 3'b111;
    // A change on line two always lasts the minimum pulse width.
    task automatic hold(input logic [2:0] lvl, input int n);
        int c;
        c = (lvl[2] != pins_out[2]) ? `EPI_T2_MIN_PULSE_CYC : n;
        @(posedge mclk_in);
        pins_out <= lvl;
        repeat (c) @(posedge mclk_in);
    endtask : hold
endmodule : epi_pins
`default_nettype wire

// File: epi_pkg.sv
// Types shared by the pin interrupt block.
`default_nettype none
package epi_pkg;

    typedef enum logic [1:0] {
        WK_IDLE,
        WK_SEEN_ONCE,
        WK_AWAKE
    } epi_wake_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } epi_bus_req_t;

    typedef struct packed {
        logic ack;
        logic [1:0] line;
    } epi_ack_t;

    typedef struct packed {
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [2:0] prev;
        logic [7:0] sense_control;
        logic [7:0] control_and_reset_status;
        logic [7:0] line_enable;
        logic [7:0] line_flags;
        logic [7:0] rdata;
        epi_wake_t wake;
    } epi_state_t;

endpackage : epi_pkg
`default_nettype wire

// File: epi_props.sv
// Port assertions of the pin interrupt controller.
`include "epi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module epi_props (
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    input wire epi_pkg::epi_bus_req_t bus_in,
    input wire logic [7:0] rdata_out,
    input wire logic ext_line_zero_in,
    input wire logic ext_line_one_in,
    input wire logic ext_line_two_in,
    input wire logic global_enable_in,
    input wire epi_pkg::epi_ack_t ack_in,
    input wire logic sleep_in,
    input wire logic line_two_buf_off_in,
    input wire logic wdt_tick_in,
    input wire logic [2:0] req_out,
    input wire logic irq_out,
    input wire logic wake_out
);
    logic [7:0] sense_r, enable_r;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    // Shadows of the registers that qualify the requests.
    always_ff @(posedge mclk_in) begin
        if (sys_rst_in) begin
            sense_r <= 8'h00;
            enable_r <= 8'h00;
        end else if (bus_in.wr) begin
            if (bus_in.addr == `EPI_OFS_SENSE) sense_r <= bus_in.wdata;
            if (bus_in.addr == `EPI_OFS_ENABLE) enable_r <= bus_in.wdata;
        end
    end
    a_read_one_cycle: assert property (!bus_in.rd |=> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    a_irq_any_req: assert property (irq_out == |req_out)
        else $error("irq differs from requests");
    a_global_gates: assert property (!global_enable_in |-> !req_out)
        else $error("request without global enable");
    a_enable_gates: assert property (!enable_r[7] |-> !req_out[1])
        else $error("request while disabled");
    a_level_holds: assert property (
        sense_r[1:0] == `EPI_SENSE_LOW && enable_r[6] && global_enable_in
        && !ext_line_zero_in |-> req_out[0]) else $error("level request lost");
    a_level_no_flag: assert property (
        sense_r[1:0] == `EPI_SENSE_LOW && $past(sense_r[1:0]) == 2'h0
        && ext_line_zero_in |-> !req_out[0]) else $error("flag in level mode");
    a_rise_reaches: assert property (
        sense_r[3:2] == `EPI_SENSE_RISE && enable_r[7] && global_enable_in
        && $rose(ext_line_one_in) |-> ##[2:4] req_out[1])
        else $error("rising edge not flagged");
    a_clear_drops: assert property (
        $stable(ext_line_one_in)[*4] ##0 (sense_r[3:2] != 2'h0 && (ack_in.ack
        && ack_in.line == 2'd1 || bus_in.wr && bus_in.addr == `EPI_OFS_FLAGS
        && bus_in.wdata[7])) |=> !req_out[1]) else $error("flag not cleared");
    cover property (ack_in.ack && req_out[1]);
    cover property (req_out[0] && !ext_line_zero_in);
    cover property (wake_out);
endmodule : epi_props
bind epi_ctrl epi_props u_props (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .ext_line_zero_in(ext_line_zero_in),
    .ext_line_one_in(ext_line_one_in), .ext_line_two_in(ext_line_two_in),
    .global_enable_in(global_enable_in), .ack_in(ack_in), .sleep_in(sleep_in),
    .line_two_buf_off_in(line_two_buf_off_in), .wdt_tick_in(wdt_tick_in),
    .req_out(req_out), .irq_out(irq_out), .wake_out(wake_out));
`default_nettype wire

// File: tb_top.sv
// Self-checking bench of the pin interrupt controller.
`include "epi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    localparam logic [3:0] SNS = `EPI_OFS_SENSE;
    localparam logic [3:0] CSR = `EPI_OFS_CSR;
    localparam logic [3:0] ENA = `EPI_OFS_ENABLE;
    localparam logic [3:0] FLG = `EPI_OFS_FLAGS;
    logic mclk_in = 1'b0, sys_rst_in = 1'b1, gie = 1'b0, sleep = 1'b0;
    logic buf_off = 1'b0, tick = 1'b0, rd_seen = 1'b0, irq, wake, f;
    logic [1:0] m;
    logic [2:0] req, pins;
    logic [7:0] rdata, exp_v, d;
    logic [7:0] q[$];
    epi_pkg::epi_bus_req_t bus = '0;
    epi_pkg::epi_ack_t ack = '0;
    int bad_count = 0, n_checks = 0, seed = 32'h7d58_dc1c;
    initial forever #2.5 mclk_in = ~mclk_in;
    epi_pins PINS (.mclk_in(mclk_in), .pins_out(pins));
    epi_ctrl DUT (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .bus_in(bus),
        .rdata_out(rdata), .ext_line_zero_in(pins[0]),
        .ext_line_one_in(pins[1]), .ext_line_two_in(pins[2]),
        .global_enable_in(gie), .ack_in(ack), .sleep_in(sleep),
        .line_two_buf_off_in(buf_off), .wdt_tick_in(tick), .req_out(req),
        .irq_out(irq), .wake_out(wake));
    always @(posedge mclk_in) begin
        if (rd_seen) begin
            exp_v = q.pop_front();
            `CHK(rdata, exp_v)
        end
        rd_seen <= bus.rd;
    end
    task automatic step(input int n);
        repeat (n) @(posedge mclk_in);
        #1;
    endtask : step
    // A read notes v as its expected data; a write stores v.
    task automatic xfer(input logic [3:0] a, input logic [7:0] v, logic w);
        if (!w) q.push_back(v);
        @(posedge mclk_in);
        bus <= '{addr: a, wdata: v, wr: w, rd: !w};
        @(posedge mclk_in);
        bus <= '0;
    endtask : xfer
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #20000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        for (int a = 0; a < 4; a++) xfer(4'(a), 8'h00, 1'b0);
        xfer(4'h9, 8'h00, 1'b0);
        d = 8'($random(seed));
        xfer(SNS, d, 1'b1);
        xfer(SNS, d, 1'b0);
        xfer(CSR, d, 1'b1);
        xfer(CSR, d & 8'hDF, 1'b0);
        xfer(ENA, d, 1'b1);
        xfer(ENA, d & `EPI_ENABLE_MASK, 1'b0);
        xfer(ENA, 8'h00, 1'b1);
        $display("registers done");
        for (int k = 1; k < 4; k++) begin
            m = 2'(k);
            f = m != `EPI_SENSE_RISE;
            xfer(SNS, {4'h0, m, m}, 1'b1);
            xfer(CSR, {1'b0, !f, 6'h00}, 1'b1);
            xfer(FLG, 8'hE0, 1'b1);
            PINS.hold(3'b000, 1);
            xfer(FLG, {f, f, f, 5'h00}, 1'b0);
            xfer(FLG, 8'h00, 1'b1);
            xfer(FLG, {f, f, f, 5'h00}, 1'b0);
            xfer(FLG, 8'hE0, 1'b1);
            PINS.hold(3'b111, 1);
            f = m != `EPI_SENSE_FALL;
            xfer(FLG, {f, f, m == `EPI_SENSE_RISE, 5'h00}, 1'b0);
            xfer(FLG, 8'hE0, 1'b1);
        end
        $display("sense modes done");
        xfer(ENA, 8'h80, 1'b1);
        gie <= 1'b1;
        PINS.hold(3'b101, 6);
        step(1);
        `CHK(req, 3'b000)
        PINS.hold(3'b111, 6);
        step(1);
        `CHK(req, 3'b010)
        @(posedge mclk_in);
        gie <= 1'b0;
        step(1);
        `CHK(irq, 1'b0)
        @(posedge mclk_in);
        ack <= '{ack: 1'b1, line: 2'd1};
        gie <= 1'b1;
        @(posedge mclk_in);
        ack <= '0;
        step(1);
        `CHK(req, 3'b000)
        xfer(SNS, 8'h00, 1'b1);
        xfer(ENA, 8'h40, 1'b1);
        PINS.hold(3'b110, 2);
        step(1);
        `CHK(req, 3'b001)
        xfer(FLG, 8'h00, 1'b0);
        sleep <= 1'b1;
        repeat (4) @(posedge mclk_in) tick <= !tick;
        step(2);
        `CHK(wake, 1'b1)
        sleep <= 1'b0;
        PINS.hold(3'b111, 2);
        xfer(ENA, 8'h00, 1'b1);
        xfer(CSR, 8'h00, 1'b1);
        xfer(FLG, 8'hE0, 1'b1);
        buf_off <= 1'b1;
        step(6);
        xfer(FLG, 8'h20, 1'b0);
        xfer(ENA, 8'h20, 1'b1);
        step(1);
        `CHK({wake, req}, 4'b1100)
        @(posedge mclk_in);
        ack <= '{ack: 1'b1, line: 2'd2};
        @(posedge mclk_in);
        ack <= '0;
        step(1);
        `CHK(req, 3'b000)
        step(2);
        $display("interrupts done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
